//--- core/interrupt_accept_sequencer.sv
// What this block does
// - Unchosen shared source never sets latch
// - UART receive, serial I/O share level 10
// - External three, timer three share 15
// - External five, timer five share 16
// - Latch holds until accepted or cleared
// - Acceptance takes eight machine cycles
// - Matching return instruction ends servicing
// - First step clears master enable
// - Accepted source latch is cleared
// - Push status, PC high, PC low
// - Load PC from vector table entry
// - Acceptance starts within 38 clock periods
// - Master enable clear blocks maskable interrupts
// - Only PC and status saved automatically
// - PC low at SP-2, high SP-1
// - Maskable requests sampled in instruction final cycle
// - Trap opcode raises highest software interrupt
// - Missing memory fetch reads FFH in single-chip mode
// - Fetch from RAM/buffer/special area traps
// - Undefined opcode raises its own interrupt
// - Undefined interrupt breaks nonmaskable service
// - Maskable needs master and individual enable
// - Returns restore master enable from stack
// - Nonmaskable ignores all enable flags
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module interrupt_accept_sequencer (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [15:4]        periph_request,
  input  wire logic               uart_receive_request,
  input  wire logic               serial_io_request,
  input  wire logic               external_input_three,
  input  wire logic               timer_three_request,
  input  wire logic               external_input_five,
  input  wire logic               timer_five_request,
  input  wire logic               single_chip_pin,
  input  wire logic               instr_final_cycle,
  input  wire logic               fetch_valid,
  input  wire logic [15:0]        fetch_addr,
  input  wire logic [7:0]         fetch_opcode,
  input  wire logic               fetch_mem_present,
  input  wire logic               opcode_defined,
  input  wire logic               ret_valid,
  input  wire logic               ret_nonmaskable,
  input  wire logic [7:0]         ret_status,
  input  wire logic [15:0]        pc_in,
  input  wire logic [7:0]         psw_in,
  input  wire logic [15:0]        sp_in,
  input  wire logic [15:0]        vec_data,
  output logic                    fetch_out_valid,
  output logic      [7:0]         fetch_out_opcode,
  output logic                    cpu_hold,
  output irq_pkg::stack_push_s    stack_push,
  output logic                    vec_rd,
  output logic      [15:0]        vec_addr,
  output irq_pkg::load16_s        pc_load,
  output irq_pkg::load16_s        sp_load,
  output logic                    trap_reset
);
  import irq_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0] enable_q;
  logic [15:0] latch_q;
  logic [2:0]  select_q;
  logic        cfg_trapint_q;
  logic        sc_meta_q;
  logic        sc_sync_q;
  logic        sw_pend_q;
  logic        undef_pend_q;
  logic        trap_pend_q;
  logic        nmi_busy_q;
  logic        late_q;
  logic [5:0]  wait_cnt_q;
  seq_state_e  state_q;
  logic [2:0]  step_q;
  logic [1:0]  div_q;
  logic [3:0]  level_q;
  logic [7:0]  psw_save_q;
  logic [15:0] pc_save_q;
  logic [15:0] sp_save_q;
  logic [15:0] vec_q;
  logic [15:0] set_vec;
  logic [15:0] masked;
  logic        mc_tick;
  logic        wr_en;
  logic        rd_en;
  logic        start;
  logic [3:0]  win_level;
  logic        win_valid;
  logic        win_nmi;
  logic [7:0]  eff_opcode;
  logic        in_trap_area;
  logic        fetch_sw;
  logic        fetch_undef;
  logic        fetch_trap;

  // ----------------------------------------
  // Source routing and shared levels
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_src
      if (gi == LVL_P10) begin : g_p10
        assign set_vec[gi] = select_q[SEL_LVL10_BIT] ? serial_io_request
                                                     : uart_receive_request;
      end else if (gi == LVL_P15) begin : g_p15
        assign set_vec[gi] = select_q[SEL_LVL15_BIT] ? timer_three_request
                                                     : external_input_three;
      end else if (gi == LVL_P16) begin : g_p16
        assign set_vec[gi] = select_q[SEL_LVL16_BIT] ? timer_five_request
                                                     : external_input_five;
      end else if (gi >= LVL_MASK_LO) begin : g_plain
        assign set_vec[gi] = periph_request[gi];
      end else begin : g_none
        assign set_vec[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // Strap synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_meta_q <= 1'b0;
      sc_sync_q <= 1'b0;
    end else begin
      sc_meta_q <= single_chip_pin;
      sc_sync_q <= sc_meta_q;
    end
  end

  // ----------------------------------------
  // Fetch checks
  // ----------------------------------------
  always_comb begin
    eff_opcode = (sc_sync_q && !fetch_mem_present) ? OP_TRAP : fetch_opcode;
    in_trap_area = (fetch_addr <= SFR_HI)
                || (fetch_addr >= RAM_LO && fetch_addr <= RAM_HI)
                || (fetch_addr >= DBR_LO && fetch_addr <= DBR_HI);
    fetch_trap  = fetch_valid && in_trap_area;
    fetch_sw    = fetch_valid && !in_trap_area && (eff_opcode == OP_TRAP);
    fetch_undef = fetch_valid && !in_trap_area && !fetch_sw && !opcode_defined;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_out_valid  <= 1'b0;
      fetch_out_opcode <= 8'h00;
      trap_reset       <= 1'b0;
    end else begin
      fetch_out_valid  <= fetch_valid;
      fetch_out_opcode <= eff_opcode;
      trap_reset       <= fetch_trap && !cfg_trapint_q;
    end
  end

  // ----------------------------------------
  // Nonmaskable pending flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_pend_q    <= 1'b0;
      undef_pend_q <= 1'b0;
      trap_pend_q  <= 1'b0;
    end else begin
      if (fetch_sw) begin
        sw_pend_q <= 1'b1;
      end else if (start && win_level == 4'(LVL_SW)) begin
        sw_pend_q <= 1'b0;
      end
      if (fetch_undef) begin
        undef_pend_q <= 1'b1;
      end else if (start && win_level == 4'(LVL_UNDEF)) begin
        undef_pend_q <= 1'b0;
      end
      if (fetch_trap && cfg_trapint_q) begin
        trap_pend_q <= 1'b1;
      end else if (start && win_level == 4'(LVL_TRAP)) begin
        trap_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Priority selection
  // ----------------------------------------
  always_comb begin
    masked = enable_q[MEF_BIT] ? (latch_q & enable_q) : 16'h0000;
    masked[LVL_MASK_LO-1:0] = 4'h0;
    win_valid = 1'b1;
    win_nmi   = 1'b1;
    win_level = 4'(LVL_SW);
    if (sw_pend_q) begin
      win_level = 4'(LVL_SW);
    end else if (undef_pend_q) begin
      win_level = 4'(LVL_UNDEF);
    end else if (trap_pend_q) begin
      win_level = 4'(LVL_TRAP);
    end else begin
      win_nmi   = 1'b0;
      win_valid = 1'b0;
      for (int i = 15; i >= LVL_MASK_LO; i--) begin
        if (masked[i]) begin
          win_valid = 1'b1;
          win_level = 4'(i);
        end
      end
    end
  end

  // Nonmaskable starts at once
  assign start = (state_q == ST_IDLE) && win_valid
              && (win_nmi || instr_final_cycle);

  // ----------------------------------------
  // Request latches
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= LATCH_RESET;
    end else begin
      for (int i = LVL_MASK_LO; i < 16; i++) begin
        if (set_vec[i]) begin
          latch_q[i] <= 1'b1;
        end else if (start && !win_nmi && win_level == 4'(i)) begin
          latch_q[i] <= 1'b0;
        end else if (wr_en && paddr == OFS_LATCH && !pwdata[i]) begin
          latch_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= ENABLE_RESET;
    end else begin
      if (wr_en && paddr == OFS_ENABLE) begin
        enable_q <= {pwdata[15:4], 3'b000, pwdata[MEF_BIT]};
      end
      if (start) begin
        enable_q[MEF_BIT] <= 1'b0;
      end else if (ret_valid && state_q == ST_IDLE) begin
        enable_q[MEF_BIT] <= ret_status[MEF_BIT];
      end
    end
  end

  // ----------------------------------------
  // Select and config registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_q      <= SELECT_RESET;
      cfg_trapint_q <= 1'b0;
    end else begin
      if (wr_en && paddr == OFS_SELECT) begin
        select_q <= pwdata[2:0];
      end
      if (wr_en && paddr == OFS_CONFIG) begin
        cfg_trapint_q <= pwdata[CFG_TRAPINT_BIT];
      end
    end
  end

  // ----------------------------------------
  // Nonmaskable service tracking
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_busy_q <= 1'b0;
    end else begin
      if (start && win_nmi) begin
        nmi_busy_q <= 1'b1;
      end else if (ret_valid && ret_nonmaskable && state_q == ST_IDLE) begin
        nmi_busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Acceptance latency monitor
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_q <= 6'd0;
      late_q     <= 1'b0;
    end else begin
      if (masked == 16'h0000 || start) begin
        wait_cnt_q <= 6'd0;
      end else if (state_q == ST_IDLE && wait_cnt_q != 6'h3F) begin
        wait_cnt_q <= wait_cnt_q + 6'd1;
      end
      if (wait_cnt_q > 6'(LATENCY_CLKS)) begin
        late_q <= 1'b1;
      end else if (wr_en && paddr == OFS_STATUS) begin
        late_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Machine cycle divider
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'd0;
    end else if (start || div_q == 2'(MC_CLKS - 1)) begin
      div_q <= 2'd0;
    end else begin
      div_q <= div_q + 2'd1;
    end
  end
  assign mc_tick = (state_q == ST_ACCEPT) && (div_q == 2'(MC_CLKS - 1));

  // ----------------------------------------
  // Acceptance sequence
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_IDLE;
      step_q     <= 3'd0;
      level_q    <= 4'd0;
      psw_save_q <= 8'h00;
      pc_save_q  <= 16'h0000;
      sp_save_q  <= 16'h0000;
      vec_q      <= 16'h0000;
      cpu_hold   <= 1'b0;
      stack_push <= '0;
      vec_rd     <= 1'b0;
      vec_addr   <= 16'h0000;
      pc_load    <= '0;
      sp_load    <= '0;
    end else begin
      stack_push.we <= 1'b0;
      vec_rd        <= 1'b0;
      pc_load.load  <= 1'b0;
      sp_load.load  <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q    <= ST_ACCEPT;
            step_q     <= 3'd0;
            level_q    <= win_level;
            cpu_hold   <= 1'b1;
            psw_save_q <= {psw_in[7:1], enable_q[MEF_BIT]};
            pc_save_q  <= pc_in;
            sp_save_q  <= sp_in;
          end
        end
        ST_ACCEPT: begin
          if (mc_tick) begin
            step_q <= step_q + 3'd1;
            unique case (step_q)
              3'd0: begin
                stack_push <= '{we: 1'b1, addr: sp_save_q, data: psw_save_q};
              end
              3'd1: begin
                stack_push <= '{we: 1'b1, addr: sp_save_q - 16'd1,
                                data: pc_save_q[15:8]};
              end
              3'd2: begin
                stack_push <= '{we: 1'b1, addr: sp_save_q - 16'd2,
                                data: pc_save_q[7:0]};
              end
              3'd3: begin
                vec_rd   <= 1'b1;
                vec_addr <= VEC_TOP - {11'd0, level_q, 1'b0};
              end
              3'd4: begin
                vec_q <= vec_data;
              end
              3'd5: begin
                sp_load <= '{load: 1'b1, value: sp_save_q - 16'd3};
              end
              3'd6: begin
                pc_load <= '{load: 1'b1, value: vec_q};
              end
              3'd7: begin
                state_q  <= ST_IDLE;
                cpu_hold <= 1'b0;
              end
              default: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pslverr <= !(paddr == OFS_ENABLE || paddr == OFS_LATCH || paddr == OFS_SELECT
                  || paddr == OFS_CONFIG || paddr == OFS_STATUS);
      end
      if (rd_en) begin
        unique case (paddr)
          OFS_ENABLE: prdata <= {16'h0000, enable_q};
          OFS_LATCH:  prdata <= {16'h0000, latch_q};
          OFS_SELECT: prdata <= {29'h0000_0000, select_q};
          OFS_CONFIG: prdata <= {31'h0000_0000, cfg_trapint_q};
          OFS_STATUS: prdata <= {20'h0_0000, level_q, 1'b0, sw_pend_q, undef_pend_q,
                                 trap_pend_q, late_q, nmi_busy_q, state_q};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : interrupt_accept_sequencer
`default_nettype wire

//--- pkg/irq_pkg.sv
`default_nettype none
package irq_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned MC_PERIOD_NS    = 40;
  localparam int unsigned MC_CLKS         = (MC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCEPT_MCS      = 8;
  localparam int unsigned LATENCY_PERIODS = 38;
  localparam int unsigned LATENCY_CLKS    = LATENCY_PERIODS;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_ENABLE = 12'h000;
  localparam logic [11:0] OFS_LATCH  = 12'h004;
  localparam logic [11:0] OFS_SELECT = 12'h008;
  localparam logic [11:0] OFS_CONFIG = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int unsigned MEF_BIT       = 0;
  localparam int unsigned SEL_LVL10_BIT = 0;
  localparam int unsigned SEL_LVL15_BIT = 1;
  localparam int unsigned SEL_LVL16_BIT = 2;
  localparam int unsigned CFG_TRAPINT_BIT = 0;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET  = 16'h0000;
  localparam logic [2:0]  SELECT_RESET = 3'h0;

  // ----------------------------------------
  // Levels (index = priority - 1, low wins)
  // ----------------------------------------
  localparam int unsigned LVL_SW    = 0;
  localparam int unsigned LVL_UNDEF = 1;
  localparam int unsigned LVL_TRAP  = 2;
  localparam int unsigned LVL_MASK_LO = 4;
  localparam int unsigned LVL_P10   = 9;
  localparam int unsigned LVL_P15   = 14;
  localparam int unsigned LVL_P16   = 15;

  // ----------------------------------------
  // Memory areas and opcodes
  // ----------------------------------------
  localparam logic [15:0] SFR_LO  = 16'h0000;
  localparam logic [15:0] SFR_HI  = 16'h003F;
  localparam logic [15:0] RAM_LO  = 16'h0040;
  localparam logic [15:0] RAM_HI  = 16'h083F;
  localparam logic [15:0] DBR_LO  = 16'h0F80;
  localparam logic [15:0] DBR_HI  = 16'h0FFF;
  localparam logic [7:0]  OP_TRAP = 8'hFF;
  localparam logic [15:0] VEC_TOP = 16'hFFFE;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACCEPT = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } stack_push_s;

  typedef struct packed {
    logic        load;
    logic [15:0] value;
  } load16_s;

endpackage : irq_pkg
`default_nettype wire

//--- verif/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
  parameter logic [15:0] PC  = 16'h8A36,
  parameter logic [7:0]  PROGRAM_STATUS_WORD = 8'hA4,
  parameter logic [15:0] SP  = 16'h023F
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cpu_hold,
  input  wire logic        vec_rd,
  input  wire logic [15:0] vec_addr,
  output logic             instr_final_cycle,
  output logic      [15:0] pc_in,
  output logic      [7:0]  psw_in,
  output logic      [15:0] sp_in,
  output var logic  [15:0] vec_data
);
  // ----------------------------------------
  // Ten-cycle instructions, stalled by hold
  // ----------------------------------------
  logic [3:0] step_q;
  logic [2:0] vhold_q;
  assign pc_in  = PC;
  assign psw_in = PROGRAM_STATUS_WORD;
  assign sp_in  = SP;
  assign instr_final_cycle = (step_q == 4'd9) && !cpu_hold && presetn;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) step_q <= '0;
    else if (!cpu_hold) step_q <= (step_q == 4'd9) ? 4'd0 : step_q + 4'd1;
  end
  // Vector word valid briefly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vhold_q  <= '0;
      vec_data <= 16'h0000;
    end else if (vec_rd) begin
      vhold_q  <= 3'd6;
      vec_data <= {8'hC0, vec_addr[7:0]};
    end else if (vhold_q != 3'd0) begin
      vhold_q  <= vhold_q - 3'd1;
    end else begin
      vec_data <= ~vec_data;
    end
  end
endmodule : cpu_model
`default_nettype wire

//--- verif/interrupt_accept_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_accept_sequencer_tb_top;
  import irq_pkg::*;
  localparam logic [15:0] PC  = 16'h8A36;
  localparam logic [7:0]  PROGRAM_STATUS_WORD = 8'hA4;
  localparam logic [15:0] SP  = 16'h023F;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, single_chip_pin;
  logic instr_final_cycle, fetch_valid, fetch_mem_present, opcode_defined, ret_valid;
  logic ret_nonmaskable, fetch_out_valid, cpu_hold, vec_rd, trap_reset, trp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:4] periph_request;
  logic [5:0]  src;
  logic [15:0] fetch_addr, pc_in, sp_in, vec_data, vec_addr, vseen, pcseen, spseen;
  logic [7:0]  fetch_opcode, ret_status, psw_in, fetch_out_opcode;
  stack_push_s stack_push;
  load16_s     pc_load, sp_load;
  logic [15:0] push_a[$];
  logic [7:0]  push_d[$];
  int          n_mismatch, check_count;
  int          lv[3] = '{LVL_P10, LVL_P15, LVL_P16};

  interrupt_accept_sequencer u_interrupt_accept_sequencer (.*,
    .uart_receive_request(src[0]), .serial_io_request(src[1]),
    .external_input_three(src[2]), .timer_three_request(src[3]),
    .external_input_five(src[4]), .timer_five_request(src[5]));
  cpu_model u_cpu_model (.*);

  always #5 pclk = ~pclk;
  // ----------------------------------------
  // Monitor and helpers
  // ----------------------------------------
  always @(posedge pclk) begin
    if (stack_push.we === 1'b1) push_a.push_back(stack_push.addr);
    if (stack_push.we === 1'b1) push_d.push_back(stack_push.data);
    if (vec_rd === 1'b1) vseen = vec_addr;
    if (pc_load.load === 1'b1) pcseen = pc_load.value;
    if (sp_load.load === 1'b1) spseen = sp_load.value;
    if (trap_reset === 1'b1) trp = 1'b1;
  end
  task automatic check(input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (!wr) check(prdata, exp);
    check(pslverr, a > OFS_STATUS);
    if (n >= 20) check(1'b0, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse_src(input logic [5:0] m, input logic [15:4] p);
    @(posedge pclk);
    src <= m;
    periph_request <= p;
    @(posedge pclk);
    src <= '0;
    periph_request <= '0;
  endtask : pulse_src
  task automatic fetch(input logic [15:0] a, input logic [7:0] op, input logic pres, def);
    @(posedge pclk);
    {fetch_valid, fetch_addr, fetch_opcode, fetch_mem_present, opcode_defined} <=
      {1'b1, a, op, pres, def};
    @(posedge pclk);
    {fetch_valid, fetch_mem_present, opcode_defined} <= 3'b011;
  endtask : fetch
  task automatic ret(input logic nm, input logic mef);
    @(posedge pclk);
    {ret_valid, ret_nonmaskable, ret_status} <= {1'b1, nm, 7'h00, mef};
    @(posedge pclk);
    ret_valid <= 1'b0;
  endtask : ret
  task automatic accept(input int lvl, input logic mef);
    int n;
    logic [15:0] v;
    v = VEC_TOP - 16'(2 * lvl);
    push_a.delete();
    push_d.delete();
    for (n = 0; cpu_hold !== 1'b1 && n < 60; n++) @(posedge pclk);
    check(n <= 40, 1'b1);
    for (n = 0; cpu_hold !== 1'b0 && n < 60; n++) @(posedge pclk);
    check({push_a[0], push_a[1], push_a[2]}, {SP, SP - 16'd1, SP - 16'd2});
    check({push_d[0], push_d[1], push_d[2]}, {PROGRAM_STATUS_WORD[7:1], mef, PC});
    check({vseen, pcseen}, {v, 8'hC0, v[7:0]});
    check(spseen, SP - 16'd3);
  endtask : accept
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    print_verdict();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, src, periph_request} = '0;
    {fetch_valid, fetch_addr, fetch_opcode, ret_valid, ret_nonmaskable, ret_status} = '0;
    {single_chip_pin, fetch_mem_present, opcode_defined, trp} = 4'b1110;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_ENABLE, 0, 32'h0000_0000);
    apb(0, 12'h014, 0, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      for (int s = 0; s < 2; s++) begin
        apb(1, OFS_SELECT, 32'(s) << i, 0);
        pulse_src(6'(1 << (2 * i + 1 - s)), '0);
        apb(0, OFS_LATCH, 0, 32'h0000_0000);
        pulse_src(6'(1 << (2 * i + s)), '0);
        apb(0, OFS_LATCH, 0, 32'h1 << lv[i]);
        apb(1, OFS_LATCH, 32'h0000_0000, 0);
        apb(0, OFS_LATCH, 0, 32'h0000_0000);
      end
    end
    apb(1, OFS_ENABLE, 32'h0000_0060, 0);
    pulse_src('0, 12'h006);
    repeat (40) @(posedge pclk);
    check(cpu_hold, 1'b0);
    apb(0, OFS_LATCH, 0, 32'h0000_0060);
    apb(1, OFS_ENABLE, 32'h0000_0061, 0);
    accept(5, 1'b1);
    apb(0, OFS_LATCH, 0, 32'h0000_0040);
    apb(0, OFS_ENABLE, 0, 32'h0000_0060);
    ret(1'b0, 1'b1);
    accept(6, 1'b1);
    fetch(16'h9000, OP_TRAP, 1'b1, 1'b1);
    accept(LVL_SW, 1'b0);
    ret(1'b1, 1'b0);
    fetch(16'h9000, 8'h00, 1'b0, 1'b1);
    accept(LVL_SW, 1'b0);
    fetch(16'h9000, 8'h5A, 1'b1, 1'b0);
    accept(LVL_UNDEF, 1'b0);
    ret(1'b1, 1'b0);
    foreach (lv[i]) begin
      trp = 1'b0;
      fetch(i == 0 ? SFR_HI : (i == 1 ? RAM_LO : DBR_LO), 8'h00, 1'b1, 1'b1);
      repeat (4) @(posedge pclk);
      check(trp, 1'b1);
    end
    apb(1, OFS_CONFIG, 32'h0000_0001, 0);
    fetch(RAM_HI, 8'h00, 1'b1, 1'b1);
    accept(LVL_TRAP, 1'b0);
    ret(1'b1, 1'b0);
    print_verdict();
  end
endmodule : interrupt_accept_sequencer_tb_top
`default_nettype wire

//--- verif/irq_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module irq_seq_props (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 single_chip_pin,
  input wire logic                 fetch_valid,
  input wire logic                 fetch_mem_present,
  input wire logic                 fetch_out_valid,
  input wire logic [7:0]           fetch_out_opcode,
  input wire logic                 cpu_hold,
  input wire irq_pkg::stack_push_s stack_push,
  input wire logic                 vec_rd,
  input wire irq_pkg::load16_s     pc_load,
  input wire irq_pkg::load16_s     sp_load
);
  import irq_pkg::*;
  // ----------------------------------------
  // Acceptance bookkeeping
  // ----------------------------------------
  logic [5:0]  hold_n_q;
  logic [1:0]  push_n_q;
  logic [15:0] base_q;
  logic [15:0] last_q;
  logic        vec_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_n_q <= '0;
    else hold_n_q <= cpu_hold ? hold_n_q + 6'd1 : 6'd0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) push_n_q <= '0;
    else if (!cpu_hold) push_n_q <= '0;
    else if (stack_push.we) push_n_q <= push_n_q + 2'd1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= '0;
      last_q <= '0;
    end else if (stack_push.we) begin
      last_q <= stack_push.addr;
      if (push_n_q == 2'd0) base_q <= stack_push.addr;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vec_q <= 1'b0;
    else vec_q <= cpu_hold && (vec_q || vec_rd);
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_hold_eight_mcs:
    assert property (
      $fell(cpu_hold) |-> hold_n_q == 6'd32) else $error("acceptance length wrong");
  a_push_three:
    assert property (
      $fell(cpu_hold) |-> push_n_q == 2'd3) else $error("push count wrong");
  a_push_descend:
    assert property (
      stack_push.we && push_n_q != 2'd0 |-> stack_push.addr == last_q - 16'd1)
      else $error("push address not descending");
  a_sp_minus_three:
    assert property (
      sp_load.load |-> sp_load.value == base_q - 16'd3) else $error("new stack top wrong");
  a_vec_before_pc:
    assert property (
      pc_load.load |-> vec_q && cpu_hold) else $error("pc loaded without vector read");
  a_first_push:
    assert property (
      $rose(cpu_hold) |-> ##[1:8] stack_push.we) else $error("no push after start");
  a_pc_release:
    assert property (
      pc_load.load |-> ##[1:8] !cpu_hold) else $error("hold not released");
  a_trap_opcode:
    assert property (
      fetch_valid && !fetch_mem_present && single_chip_pin |=>
      fetch_out_valid && fetch_out_opcode == OP_TRAP) else $error("absent fetch not FF");
  a_apb_one_wait:
    assert property (
      psel && penable && !pready |=> pready) else $error("bus answer late");
endmodule : irq_seq_props

bind interrupt_accept_sequencer irq_seq_props u_irq_seq_props (.*);
`default_nettype wire
